// *** rtl/sepr_eeprom_dev.sv ***
`timescale 1ns/1ns
// Overview of operation
// - Page write stores up to eight same-row bytes.
// - Partial pages program only received bytes.
// - Acknowledge every received write data byte.
// - Write cycle starts at the Stop.
// - Page write increments only the low three address bits.
// - In-page counter wraps to page start.
// - No address acknowledge while write cycle runs.
// - Acknowledge again once write cycle ends.
// - Master polls with write address until acknowledged.
// - Ignore all accesses during write cycle.
// - Busy time runs from Stop onward.
// - Protect input high blocks all writes.
// - Protect input sampled only at Stop.
// - Protected write still acknowledged, no cycle.
// - Direction bit one selects a read.
// - Address counter holds last access plus one.
// - Read counter wraps from top to zero.
// - Current read returns byte at counter.
// - Master not acknowledging ends the read.
// - After refusal master sends Stop or Start.
// - Random read: dummy write, repeated Start, read.
// - Each master acknowledge advances sequential read.
// - Match type nibble and straps before acknowledging.
// - Word address byte follows the device address.
module sepr_eeprom_dev #(
  parameter int WR_CYCLES = sepr_pkg::WRITE_CYCLE_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Two-wire link.
  sepr_link_if.device link,
  // Board straps and write protection.
  input wire logic [sepr_pkg::STRAP_W-1:0] strap_select_inputs,
  input wire logic write_protect,
  // Status.
  output logic write_busy
);
  import sepr_pkg::*;

  typedef enum logic [4:0] {
    DS_IDLE = 5'b00001,
    DS_DEV = 5'b00010,
    DS_WORD = 5'b00100,
    DS_WDATA = 5'b01000,
    DS_RDATA = 5'b10000
  } sepr_dstate_type;

  sepr_dstate_type state_ff;
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic [1:0] wp_sync_ff;
  logic [STRAP_W-1:0] strap_meta_ff;
  logic [STRAP_W-1:0] strap_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;
  logic [3:0] cnt_ff;
  logic [DATA_W-1:0] rx_ff;
  logic [DATA_W-1:0] tx_ff;
  logic [ADDR_W-1:0] ptr_ff;
  logic ack_ff;
  logic [DATA_W-1:0] page_ff [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] valid_ff;
  logic [DATA_W-1:0] mem_ff [MEM_DEPTH];
  logic busy_ff;
  logic [BUSY_W-1:0] busy_cnt_ff;
  logic sda_oe_n_ff;
  logic sda_o_ff;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [DATA_W-1:0] nxt_rx;
  logic addr_match;
  logic commit;

  assign link.d_sda_oe_n = sda_oe_n_ff;
  assign link.d_sda_o = sda_o_ff;
  assign write_busy = busy_ff;

  // Every pin passes two flops; only the second stage is looked at below.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      wp_sync_ff <= 2'h0;
      strap_meta_ff <= '0;
      strap_ff <= '0;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], link.scl};
      sda_sync_ff <= {sda_sync_ff[0], link.sda};
      wp_sync_ff <= {wp_sync_ff[0], write_protect};
      strap_meta_ff <= strap_select_inputs;
      strap_ff <= strap_meta_ff;
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end

  // Edge and condition detection on the synchronised link.
  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];
  assign scl_rise = scl_s & ~scl_prev_ff;
  assign scl_fall = ~scl_s & scl_prev_ff;
  assign start_det = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign stop_det = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  assign nxt_rx = {rx_ff[DATA_W-2:0], sda_s};

  // Type nibble and straps must both match; a busy array answers nothing.
  assign addr_match = (nxt_rx[7:4] == DEV_TYPE_ID) && (nxt_rx[3:1] == strap_ff);

  // Protection is looked at only here, at the Stop, so a later change cannot
  // disturb a cycle already running.
  assign commit = stop_det && (state_ff == DS_WDATA) && (|valid_ff)
                  && !wp_sync_ff[1];

  // Byte framing, addressing and the page buffer.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= DS_IDLE;
      cnt_ff <= 4'h0;
      rx_ff <= '0;
      tx_ff <= ERASED_BYTE;
      ptr_ff <= '0;
      ack_ff <= 1'b0;
      valid_ff <= '0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        page_ff[i] <= ERASED_BYTE;
      end
    end else if (start_det) begin
      // A repeated Start abandons an unfinished write without programming it.
      state_ff <= DS_DEV;
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
      valid_ff <= '0;
    end else if (stop_det) begin
      state_ff <= DS_IDLE;
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
      valid_ff <= '0;
    end else if (scl_rise && (state_ff != DS_IDLE)) begin
      if (cnt_ff == BIT_ACK) begin
        cnt_ff <= 4'h0;
        ack_ff <= 1'b0;
        if ((state_ff == DS_RDATA) && !ack_ff) begin
          if (sda_s) begin
            state_ff <= DS_IDLE;
          end else begin
            tx_ff <= mem_ff[ptr_ff];
            ptr_ff <= ptr_ff + 1'b1;
          end
        end
      end else begin
        rx_ff <= nxt_rx;
        cnt_ff <= cnt_ff + 1'b1;
        if (cnt_ff == BIT_LAST) begin
          case (state_ff)
            DS_DEV: begin
              if (addr_match && !busy_ff) begin
                ack_ff <= 1'b1;
                if (nxt_rx[0] == DIR_READ) begin
                  state_ff <= DS_RDATA;
                  tx_ff <= mem_ff[ptr_ff];
                  ptr_ff <= ptr_ff + 1'b1;
                end else begin
                  state_ff <= DS_WORD;
                end
              end else begin
                state_ff <= DS_IDLE;
              end
            end
            DS_WORD: begin
              ack_ff <= 1'b1;
              ptr_ff <= nxt_rx;
              state_ff <= DS_WDATA;
            end
            DS_WDATA: begin
              ack_ff <= 1'b1;
              page_ff[ptr_ff[PAGE_W-1:0]] <= nxt_rx;
              valid_ff[ptr_ff[PAGE_W-1:0]] <= 1'b1;
              // The row bits stay put and the column wraps inside the page.
              ptr_ff <= {ptr_ff[ADDR_W-1:PAGE_W], ptr_ff[PAGE_W-1:0] + 1'b1};
            end
            default: begin
              ack_ff <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Data line drive: changes only after the clock falls so Start and Stop are
  // never faked; released at every Start or Stop.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sda_oe_n_ff <= 1'b1;
      sda_o_ff <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_oe_n_ff <= 1'b1;
    end else if (scl_fall) begin
      if ((state_ff == DS_RDATA) && (cnt_ff < BIT_ACK)) begin
        sda_oe_n_ff <= tx_ff[3'(BIT_LAST - cnt_ff)];
      end else begin
        sda_oe_n_ff <= ~((cnt_ff == BIT_ACK) && ack_ff);
      end
    end
  end

  // Self-timed write cycle; the array stays deaf until it ends.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
      busy_cnt_ff <= '0;
    end else if (commit) begin
      busy_ff <= 1'b1;
      busy_cnt_ff <= '0;
    end else if (busy_ff) begin
      if (busy_cnt_ff == BUSY_W'(WR_CYCLES - 1)) begin
        busy_ff <= 1'b0;
      end else begin
        busy_cnt_ff <= busy_cnt_ff + 1'b1;
      end
    end
  end

  // One cell per entry; a commit programs only the loaded columns of its row.
  for (genvar g = 0; g < MEM_DEPTH; g++) begin : g_cell
    localparam logic [ADDR_W-1:0] CELL = ADDR_W'(g);
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        mem_ff[g] <= ERASED_BYTE;
      end else if (commit && valid_ff[CELL[PAGE_W-1:0]]
                   && (ptr_ff[ADDR_W-1:PAGE_W] == CELL[ADDR_W-1:PAGE_W])) begin
        mem_ff[g] <= page_ff[CELL[PAGE_W-1:0]];
      end
    end
  end
endmodule // sepr_eeprom_dev

// *** rtl/sepr_fifo.sv ***
`timescale 1ns/1ns
module sepr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0] count_ff;
  logic [AW:0] nxt_count;
  logic in_ready_ff;
  logic out_valid_ff;
  logic push;
  logic pop;

  // Flags are registered so the filling side never sees a combinational path.
  assign push = in_valid & in_ready_ff;
  assign pop = out_ready & out_valid_ff;
  assign in_ready = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data = mem_ff[rptr_ff];

  // Occupancy.
  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  // Pointers wrap by overflow, so DEPTH must be a power of two.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
      in_ready_ff <= 1'b1;
      out_valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
      count_ff <= nxt_count;
      in_ready_ff <= (nxt_count != (AW+1)'(DEPTH));
      out_valid_ff <= (nxt_count != '0);
    end
  end

  // Storage needs no reset; a word is only read after it was written.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wptr_ff] <= in_data;
    end
  end
endmodule // sepr_fifo

// *** rtl/sepr_link_if.sv ***
`timescale 1ns/1ns
interface sepr_link_if;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups: a released driver reads as high.
  assign scl = m_scl_oe_n ? 1'b1 : m_scl_o;
  assign sda = (m_sda_oe_n ? 1'b1 : m_sda_o) & (d_sda_oe_n ? 1'b1 : d_sda_o);

  modport master (output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n,
                  input sda);
  modport device (output d_sda_o, output d_sda_oe_n, input scl, input sda);
endinterface

// *** rtl/sepr_master.sv ***
`timescale 1ns/1ns
module sepr_master (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Two-wire link.
  sepr_link_if.master link,
  // Command port.
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_current,
  input wire logic [sepr_pkg::STRAP_W-1:0] cmd_strap,
  input wire logic [sepr_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [sepr_pkg::LEN_W-1:0] cmd_len,
  // Write data stream.
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [sepr_pkg::FIFO_W-1:0] wr_data,
  // Read data and completion.
  output logic rd_valid,
  output logic [sepr_pkg::DATA_W-1:0] rd_data,
  output logic done,
  output logic no_ack
);
  import sepr_pkg::*;

  typedef enum logic [4:0] {
    MS_IDLE = 5'b00001,
    MS_START = 5'b00010,
    MS_LOAD = 5'b00100,
    MS_BIT = 5'b01000,
    MS_STOP = 5'b10000
  } sepr_mstate_type;

  typedef enum logic [4:0] {
    BK_DEVW = 5'b00001,
    BK_WORD = 5'b00010,
    BK_WDATA = 5'b00100,
    BK_DEVR = 5'b01000,
    BK_RDATA = 5'b10000
  } sepr_kind_type;

  sepr_mstate_type state_ff;
  sepr_kind_type kind_ff;
  logic div_ff;
  logic [1:0] phase_ff;
  logic [1:0] sda_sync_ff;
  logic [8:0] sh_ff;
  logic [8:0] rx_ff;
  logic [3:0] bit_ff;
  logic read_ff;
  logic [STRAP_W-1:0] strap_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [LEN_W-1:0] left_ff;
  logic scl_oe_n_ff;
  logic sda_oe_n_ff;
  logic cmd_ready_ff;
  logic rd_valid_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic done_ff;
  logic no_ack_ff;
  logic tick;
  logic [8:0] nxt_rx;
  logic fifo_valid;
  logic fifo_pop;
  logic [FIFO_W-1:0] fifo_data;

  assign link.m_scl_o = 1'b0;
  assign link.m_sda_o = 1'b0;
  assign link.m_scl_oe_n = scl_oe_n_ff;
  assign link.m_sda_oe_n = sda_oe_n_ff;
  assign cmd_ready = cmd_ready_ff;
  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_data_ff;
  assign done = done_ff;
  assign no_ack = no_ack_ff;
  assign tick = (div_ff == DIV_LAST);
  assign nxt_rx = {rx_ff[7:0], sda_sync_ff[1]};
  assign fifo_pop = (state_ff == MS_LOAD) && (kind_ff == BK_WDATA) && fifo_valid;

  // Write bytes wait here; an empty buffer holds the clock low until data comes.
  sepr_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // Phase divider and data line synchroniser.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_ff <= 1'b0;
      sda_sync_ff <= 2'h3;
    end else begin
      div_ff <= ~div_ff;
      sda_sync_ff <= {sda_sync_ff[0], link.sda};
    end
  end

  // Transaction sequencer: data moves only while the clock is low, except at Start and Stop.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= MS_IDLE;
      kind_ff <= BK_DEVW;
      phase_ff <= PH_SETUP;
      sh_ff <= '1;
      rx_ff <= '0;
      bit_ff <= 4'h0;
      read_ff <= 1'b0;
      strap_ff <= '0;
      addr_ff <= '0;
      left_ff <= '0;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
      cmd_ready_ff <= 1'b1;
      rd_valid_ff <= 1'b0;
      rd_data_ff <= '0;
      done_ff <= 1'b0;
      no_ack_ff <= 1'b0;
    end else begin
      rd_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      case (state_ff)
        MS_IDLE: begin
          if (cmd_valid && cmd_ready_ff) begin
            cmd_ready_ff <= 1'b0;
            no_ack_ff <= 1'b0;
            read_ff <= cmd_read;
            strap_ff <= cmd_strap;
            addr_ff <= cmd_addr;
            left_ff <= cmd_len;
            kind_ff <= (cmd_read && cmd_current) ? BK_DEVR : BK_DEVW;
            phase_ff <= PH_SETUP;
            state_ff <= MS_START;
          end
        end
        MS_START: begin
          if (tick) begin
            phase_ff <= phase_ff + 1'b1;
            case (phase_ff)
              PH_SETUP: sda_oe_n_ff <= 1'b1;
              PH_RISE: scl_oe_n_ff <= 1'b1;
              PH_HIGH: sda_oe_n_ff <= 1'b0;
              default: begin
                scl_oe_n_ff <= 1'b0;
                state_ff <= MS_LOAD;
              end
            endcase
          end
        end
        MS_LOAD: begin
          bit_ff <= 4'h0;
          phase_ff <= PH_SETUP;
          state_ff <= MS_BIT;
          case (kind_ff)
            BK_DEVW: sh_ff <= {DEV_TYPE_ID, strap_ff, DIR_WRITE, 1'b1};
            BK_DEVR: sh_ff <= {DEV_TYPE_ID, strap_ff, DIR_READ, 1'b1};
            BK_WORD: sh_ff <= {addr_ff, 1'b1};
            BK_RDATA: sh_ff <= {8'hff, (left_ff <= 4'h1)};
            default: begin
              sh_ff <= {fifo_data, 1'b1};
              if (!fifo_valid) begin
                state_ff <= MS_LOAD;
              end
            end
          endcase
        end
        MS_BIT: begin
          if (tick) begin
            phase_ff <= phase_ff + 1'b1;
            case (phase_ff)
              PH_SETUP: sda_oe_n_ff <= sh_ff[8];
              PH_RISE: scl_oe_n_ff <= 1'b1;
              PH_HIGH: scl_oe_n_ff <= 1'b1;
              default: begin
                scl_oe_n_ff <= 1'b0;
                rx_ff <= nxt_rx;
                sh_ff <= {sh_ff[7:0], 1'b1};
                bit_ff <= bit_ff + 1'b1;
                if (bit_ff == BIT_ACK) begin
                  state_ff <= MS_LOAD;
                  case (kind_ff)
                    BK_DEVW: begin
                      kind_ff <= BK_WORD;
                      if (nxt_rx[0]) begin
                        no_ack_ff <= 1'b1;
                        state_ff <= MS_STOP;
                      end
                    end
                    BK_WORD: begin
                      if (nxt_rx[0] || (!read_ff && (left_ff == 4'h0))) begin
                        no_ack_ff <= nxt_rx[0];
                        state_ff <= MS_STOP;
                      end else if (read_ff) begin
                        kind_ff <= BK_DEVR;
                        state_ff <= MS_START;
                      end else begin
                        kind_ff <= BK_WDATA;
                      end
                    end
                    BK_WDATA: begin
                      left_ff <= left_ff - 1'b1;
                      if (nxt_rx[0] || (left_ff <= 4'h1)) begin
                        no_ack_ff <= nxt_rx[0];
                        state_ff <= MS_STOP;
                      end
                    end
                    BK_DEVR: begin
                      kind_ff <= BK_RDATA;
                      if (nxt_rx[0]) begin
                        no_ack_ff <= 1'b1;
                        state_ff <= MS_STOP;
                      end
                    end
                    default: begin
                      rd_valid_ff <= 1'b1;
                      rd_data_ff <= nxt_rx[8:1];
                      left_ff <= left_ff - 1'b1;
                      if (left_ff <= 4'h1) begin
                        state_ff <= MS_STOP;
                      end
                    end
                  endcase
                end
              end
            endcase
          end
        end
        default: begin
          if (tick) begin
            phase_ff <= phase_ff + 1'b1;
            case (phase_ff)
              PH_SETUP: sda_oe_n_ff <= 1'b0;
              PH_RISE: scl_oe_n_ff <= 1'b1;
              PH_HIGH: sda_oe_n_ff <= 1'b1;
              default: begin
                done_ff <= 1'b1;
                cmd_ready_ff <= 1'b1;
                state_ff <= MS_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end
endmodule // sepr_master

// *** rtl/sepr_pkg.sv ***
package sepr_pkg;

  // Array geometry: 32 rows of 8 bytes behind an 8-bit word address.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int STRAP_W = 3;
  localparam int PAGE_W = 3;
  localparam int PAGE_BYTES = 8;
  localparam int MEM_DEPTH = 256;
  localparam int LEN_W = 4;

  // Device type nibble of the device address byte; the value is arbitrary.
  localparam logic [3:0] DEV_TYPE_ID = 4'h5;

  // Contents of every cell after reset.
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Bit counter landmarks within one nine-clock byte.
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // Direction bit values.
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // Self-timed write cycle.
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int WRITE_CYCLE_TIME_US = 1000;
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int BUSY_W = 16;

  // Master clock generation: four phases of two cycles each make an 800 ns clock.
  localparam logic DIV_LAST = 1'b1;
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  // Write data buffer in front of the master.
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 8;

endpackage

// *** verif/sepr_link_properties.sv ***
`timescale 1ns/1ns
module sepr_link_properties #(
  parameter int WR_CYCLES = 200
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Resolved wires and the device drive.
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_oe_n,
  // Device status and protection.
  input wire logic write_busy,
  input wire logic write_protect
);
  logic [15:0] busy_cnt_ff;
  logic [3:0] since_stop_ff;
  logic sda_ff;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Length of the current write cycle so far.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) busy_cnt_ff <= 16'h0;
    else busy_cnt_ff <= write_busy ? busy_cnt_ff + 16'h1 : 16'h0;
  end
  // Previous data level, used to spot a Stop on the wire.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) sda_ff <= 1'b1;
    else sda_ff <= sda;
  end
  // Cycles since the last Stop; it saturates so it never wraps into range again.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) since_stop_ff <= 4'hf;
    else if (scl && sda && !sda_ff) since_stop_ff <= 4'h0;
    else if (since_stop_ff != 4'hf) since_stop_ff <= since_stop_ff + 4'h1;
  end
  a_busy_silent: assert property (write_busy |-> d_sda_oe_n)
    else $error("device drove data during write cycle");
  a_busy_after_stop: assert property ($rose(write_busy) |-> since_stop_ff inside {[4'h1:4'h8]})
    else $error("write cycle began away from a Stop");
  a_busy_length: assert property ($fell(write_busy) |->
    busy_cnt_ff >= WR_CYCLES && busy_cnt_ff <= WR_CYCLES + 1)
    else $error("write cycle length wrong");
  // The device judges protection from the level seen three edges before the rise.
  a_wp_blocks: assert property ($rose(write_busy) |-> !$past(write_protect, 3))
    else $error("write cycle began while protected");
  a_wp_no_abort: assert property (write_busy && busy_cnt_ff < WR_CYCLES - 2 |=> write_busy)
    else $error("write cycle cut short");
  a_dev_drive_low: assert property ($fell(d_sda_oe_n) |-> !scl)
    else $error("device began driving while clock high");
  a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(d_sda_oe_n))
    else $error("device drive changed while clock high");
  a_scl_high_min: assert property ($rose(scl) |-> scl[*3])
    else $error("clock high phase too short");
endmodule // sepr_link_properties

// *** verif/test_serial_eeprom_page_write_and_read.sv ***
`timescale 1ns/1ns
module test_serial_eeprom_page_write_and_read;
  import sepr_pkg::*;
  localparam logic [2:0] STRAP = 3'h5;
  logic ref_clk, resetn, write_protect, write_busy, cmd_valid, cmd_ready, cmd_read;
  logic cmd_current, wr_valid, wr_ready, rd_valid, done, no_ack;
  logic [2:0] cmd_strap;
  logic [3:0] cmd_len;
  logic [7:0] cmd_addr, wr_data, rd_data;
  logic [7:0] rdq[$];
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int c;
  sepr_link_if u_sepr_link_if ();
  sepr_master u_sepr_master (.ref_clk(ref_clk), .resetn(resetn), .link(u_sepr_link_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_current(cmd_current), .cmd_strap(cmd_strap), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .no_ack(no_ack));
  sepr_eeprom_dev #(.WR_CYCLES(200)) u_sepr_eeprom_dev (.ref_clk(ref_clk), .resetn(resetn),
    .link(u_sepr_link_if), .strap_select_inputs(STRAP), .write_protect(write_protect),
    .write_busy(write_busy));
  sepr_link_properties #(.WR_CYCLES(200)) u_sepr_link_properties (.ref_clk(ref_clk),
    .resetn(resetn), .scl(u_sepr_link_if.scl), .sda(u_sepr_link_if.sda),
    .d_sda_oe_n(u_sepr_link_if.d_sda_oe_n), .write_busy(write_busy),
    .write_protect(write_protect));
  // The clock flips every half period.
  always #50 ref_clk = ~ref_clk;
  // A hang is cut short well after the longest expected run.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc >= 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Valid stays up across a burst so it is never lowered and raised in one step.
  task automatic push(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge ref_clk);
      wr_valid = 1'b1;
      wr_data = b[i];
      @(posedge ref_clk);
      while (wr_ready !== 1'b1) @(posedge ref_clk);
    end
    @(negedge ref_clk);
    wr_valid = 1'b0;
  endtask
  // One command, held until taken; read bytes are gathered until done pulses.
  task automatic run(input logic rd, input logic cur, input logic [2:0] st,
                     input logic [7:0] ad, input logic [3:0] ln);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_current = cur;
    cmd_strap = st;
    cmd_addr = ad;
    cmd_len = ln;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1) @(posedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    rdq.delete();
    do begin
      @(posedge ref_clk);
      if (rd_valid === 1'b1) rdq.push_back(rd_data);
    end while (done !== 1'b1);
    @(negedge ref_clk);
  endtask
  // Polling with an address-only write until the device answers again.
  task automatic settle;
    int k;
    k = 0;
    do begin
      run(1'b0, 1'b0, STRAP, 8'h00, 4'h0);
      k++;
    end while (no_ack !== 1'b0 && k < 20);
    chk({7'h0, no_ack}, 8'h0);
  endtask
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    write_protect = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_current = 1'b0;
    cmd_strap = 3'h0;
    cmd_addr = 8'h00;
    cmd_len = 4'h0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    // Full page from column 3, so the last bytes wrap to the page start.
    push({8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7});
    chk({7'h0, wr_ready}, 8'h0);
    run(1'b0, 1'b0, STRAP, 8'h13, 4'h8);
    chk({7'h0, no_ack}, 8'h0);
    run(1'b0, 1'b0, STRAP, 8'h13, 4'h0);
    chk({7'h0, no_ack}, 8'h1);
    settle();
    run(1'b1, 1'b0, STRAP, 8'h10, 4'h4);
    for (c = 0; c < 4; c++) chk(rdq[c], 8'ha0 + 8'((c + 5) & 7));
    chk(8'(rdq.size()), 8'h4);
    run(1'b1, 1'b1, STRAP, 8'h00, 4'h4);
    for (c = 4; c < 8; c++) chk(rdq[c - 4], 8'ha0 + 8'((c + 5) & 7));
    // Partial page at the top of the array, then a read across the end.
    push({8'h5a, 8'h3c});
    run(1'b0, 1'b0, STRAP, 8'hfe, 4'h2);
    settle();
    run(1'b1, 1'b0, STRAP, 8'hfd, 4'h4);
    chk(rdq[0], 8'hff);
    chk(rdq[1], 8'h5a);
    chk(rdq[2], 8'h3c);
    chk(rdq[3], 8'hff);
    // Protected write is acknowledged but starts no cycle.
    write_protect = 1'b1;
    push({8'h00});
    run(1'b0, 1'b0, STRAP, 8'hfe, 4'h1);
    chk({7'h0, no_ack}, 8'h0);
    chk({7'h0, write_busy}, 8'h0);
    run(1'b0, 1'b0, STRAP, 8'h00, 4'h0);
    chk({7'h0, no_ack}, 8'h0);
    write_protect = 1'b0;
    // Protection raised after the Stop must not stop the write.
    push({8'h77});
    run(1'b0, 1'b0, STRAP, 8'h20, 4'h1);
    repeat (10) @(negedge ref_clk);
    write_protect = 1'b1;
    settle();
    write_protect = 1'b0;
    run(1'b1, 1'b0, STRAP, 8'hfe, 4'h1);
    chk(rdq[0], 8'h5a);
    run(1'b1, 1'b0, STRAP, 8'h20, 4'h1);
    chk(rdq[0], 8'h77);
    // A foreign strap value is refused in both directions.
    run(1'b0, 1'b0, 3'h2, 8'h00, 4'h0);
    chk({7'h0, no_ack}, 8'h1);
    run(1'b1, 1'b1, 3'h4, 8'h00, 4'h1);
    chk({7'h0, no_ack}, 8'h1);
    give_verdict();
  end
endmodule // test_serial_eeprom_page_write_and_read
